/* File: rtl/slave_event_flags.sv */
// Two-wire serial slave with event flags, APB registers and a link clock domain
//
// How it works
// (RL1) transmit_direction is high while the slave transmits and low while it receives.
// (RL2) first_byte_indicator rises when the data register holds the first byte after a match.
// (RL3) first_byte_indicator falls once software reads that first byte from the data register.
// (RL4) With dual_address_enable set the address LSB is ignored, so two addresses match.
// (RL5) An address match sets address_match_flag and the interrupt; software clears it.
// (RL6) A STOP on SCL and SDA sets stop_detected_flag, which holds until software clears it.
// (RL7) Software clears a sticky flag by writing zero to its bit; writing one leaves it.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`include "slave_flags_defines.svh"

module slave_event_flags
  import slave_flags_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             slave_irq,
  input  wire logic        link_clk,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe
);

  // Address compare, optionally ignoring the LSB
  function automatic logic addr_match(input logic [6:0] rx_addr,
                                      input logic [6:0] own,
                                      input logic       dual);
    if (dual) begin
      addr_match = (rx_addr[6:1] == own[6:1]);
    end else begin
      addr_match = (rx_addr == own);
    end
  endfunction : addr_match

  // Bus side state
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  logic         irq_q;
  logic         dual_q;
  logic [6:0]   own_addr_q;
  logic [7:0]   tx_data_q;
  logic         cfg_tgl_q;
  logic         match_flag_q;
  logic         stop_flag_q;
  logic         first_byte_q;
  logic         first_pending_q;
  logic [7:0]   rx_data_q;
  logic [2:0]   evt_s1_q;
  logic [2:0]   evt_s2_q;
  logic [2:0]   evt_p_q;
  logic [1:0]   xmt_sync_q;

  // Link side state
  logic [1:0]     link_rst_q;
  logic           link_rstn;
  logic [1:0]     scl_sync_q;
  logic [1:0]     sda_sync_q;
  logic           scl_p_q;
  logic           sda_p_q;
  logic [1:0]     cfg_sync_q;
  logic           cfg_p_q;
  link_cfg_type   cfg_q;
  link_state_type state_q;
  logic [3:0]     bit_cnt_q;
  logic [7:0]     shift_q;
  logic [7:0]     tx_sh_q;
  logic [7:0]     rx_byte_q;
  logic           oe_q;
  logic           xmt_q;
  link_evt_type   evt_q;

  // Decoded bus strobes; full decode, so no register aliases
  wire logic setup_ph   = psel & ~penable;
  wire logic access_ph  = psel & penable;
  wire logic wr_acc     = access_ph & pwrite;
  wire logic rd_acc     = access_ph & ~pwrite;
  wire logic hit_flags  = (paddr == `SLAVE_EVENT_FLAGS_ADDR);
  wire logic hit_status = (paddr == `SLAVE_STATUS_ADDR);
  wire logic hit_own    = (paddr == `OWN_ADDRESS_ADDR);
  wire logic hit_data   = (paddr == `SLAVE_DATA_ADDR);
  wire logic mapped     = hit_flags | hit_status | hit_own | hit_data;

  // Event edges seen on the synchronised toggles
  wire logic evt_match  = evt_s2_q[2] ^ evt_p_q[2];
  wire logic evt_stop   = evt_s2_q[1] ^ evt_p_q[1];
  wire logic evt_rx     = evt_s2_q[0] ^ evt_p_q[0];
  wire logic first_read = rd_acc & hit_data;

  // (RL7) Write zero clears
  wire logic clr_match  = wr_acc & hit_flags & ~pwdata[`ADDRESS_MATCH_BIT];
  wire logic clr_stop   = wr_acc & hit_flags & ~pwdata[`STOP_DETECTED_BIT];

  // Zero wait states: read data and error are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= 1'b1;
      if (setup_ph) begin
        pslverr_q <= ~mapped;
        prdata_q  <= 32'h0000_0000;
        if (!pwrite && hit_flags) begin
          prdata_q[`FIRST_BYTE_BIT]    <= first_byte_q;
          prdata_q[`ADDRESS_MATCH_BIT] <= match_flag_q;
          prdata_q[`STOP_DETECTED_BIT] <= stop_flag_q;
        end
        if (!pwrite && hit_status) begin
          prdata_q[`TRANSMIT_DIRECTION_BIT] <= xmt_sync_q[1];
        end
        if (!pwrite && hit_own) begin
          prdata_q[6:0] <= own_addr_q;
        end
        if (!pwrite && hit_data) begin
          prdata_q[7:0] <= rx_data_q;
        end
      end
    end
  end

  // Configuration written by software; a toggle tells the link side to recapture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dual_q     <= 1'b0;
      own_addr_q <= `OWN_ADDRESS_RST;
      tx_data_q  <= `TX_DATA_RST;
      cfg_tgl_q  <= 1'b0;
    end else if (wr_acc) begin
      if (hit_flags) begin
        dual_q    <= pwdata[`DUAL_ADDRESS_BIT];
        cfg_tgl_q <= ~cfg_tgl_q;
      end
      if (hit_own) begin
        own_addr_q <= pwdata[6:0];
        cfg_tgl_q  <= ~cfg_tgl_q;
      end
      if (hit_data) begin
        tx_data_q <= pwdata[7:0];
        cfg_tgl_q <= ~cfg_tgl_q;
      end
    end
  end

  // Bring link events and the direction level into the bus domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_s1_q   <= 3'h0;
      evt_s2_q   <= 3'h0;
      evt_p_q    <= 3'h0;
      xmt_sync_q <= 2'h0;
    end else begin
      evt_s1_q   <= evt_q;
      evt_s2_q   <= evt_s1_q;
      evt_p_q    <= evt_s2_q;
      xmt_sync_q <= {xmt_sync_q[0], xmt_q};
    end
  end

  // Sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag_q <= 1'b0;
      stop_flag_q  <= 1'b0;
    end else begin
      // (RL5) Match flag sticky
      if (evt_match) begin
        match_flag_q <= 1'b1;
      end else if (clr_match) begin
        match_flag_q <= 1'b0;
      end
      // (RL6) Stop flag sticky
      if (evt_stop) begin
        stop_flag_q <= 1'b1;
      end else if (clr_stop) begin
        stop_flag_q <= 1'b0;
      end
    end
  end

  // Received bytes land here; the first one after a match is marked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_q       <= 8'h00;
      first_byte_q    <= 1'b0;
      first_pending_q <= 1'b0;
    end else begin
      if (evt_rx) begin
        rx_data_q <= rx_byte_q;
      end
      if (evt_match) begin
        first_pending_q <= 1'b1;
        first_byte_q    <= 1'b0;
      end else if (evt_rx) begin
        first_pending_q <= 1'b0;
        // (RL2) Mark first byte
        first_byte_q    <= first_pending_q;
      end else if (first_read) begin
        // (RL3) Read clears mark
        first_byte_q <= 1'b0;
      end
    end
  end

  // (RL5) Interrupt follows flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= match_flag_q | stop_flag_q;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign slave_irq = irq_q;

  // Link domain

  // Reset release is synchronised so the link FSM leaves reset cleanly
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      link_rst_q <= 2'b00;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b1};
    end
  end

  assign link_rstn = link_rst_q[1];

  // Pins pass two flops; a third stage gives the previous level for edges
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_p_q    <= 1'b1;
      sda_p_q    <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_p_q    <= scl_sync_q[1];
      sda_p_q    <= sda_sync_q[1];
    end
  end

  // Config words are stable while their toggle crosses; back-to-back writes
  // faster than three link clocks may be captured late but never torn
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      cfg_sync_q <= 2'b00;
      cfg_p_q    <= 1'b0;
      cfg_q      <= '0;
    end else begin
      cfg_sync_q <= {cfg_sync_q[0], cfg_tgl_q};
      cfg_p_q    <= cfg_sync_q[1];
      if (cfg_sync_q[1] ^ cfg_p_q) begin
        cfg_q <= '{dual_address_enable: dual_q, own_address: own_addr_q,
                   tx_byte: tx_data_q};
      end
    end
  end

  // Line levels and bus conditions after the synchroniser
  wire logic scl_s     = scl_sync_q[1];
  wire logic sda_s     = sda_sync_q[1];
  wire logic scl_rise  = scl_s & ~scl_p_q;
  wire logic scl_fall  = ~scl_s & scl_p_q;
  wire logic start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  wire logic stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Slave protocol engine; SDA changes only after SCL falls
  always_ff @(posedge link_clk or negedge link_rstn) begin
    if (!link_rstn) begin
      state_q   <= LINK_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      tx_sh_q   <= 8'h00;
      rx_byte_q <= 8'h00;
      oe_q      <= 1'b0;
      xmt_q     <= 1'b0;
      evt_q     <= '0;
    end else if (start_det) begin
      state_q   <= LINK_ADDR;
      bit_cnt_q <= 4'h0;
      oe_q      <= 1'b0;
    end else if (stop_det) begin
      state_q    <= LINK_IDLE;
      oe_q       <= 1'b0;
      xmt_q      <= 1'b0;
      // (RL6) Stop seen
      evt_q.stop_tgl <= ~evt_q.stop_tgl;
    end else begin
      unique case (state_q)
        LINK_IDLE: begin
          oe_q <= 1'b0;
        end
        LINK_ADDR: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
            // (RL4) Optional LSB ignore
            if (addr_match(shift_q[7:1], cfg_q.own_address, cfg_q.dual_address_enable)) begin
              oe_q            <= 1'b1;
              // (RL1) Direction from R/W
              xmt_q           <= shift_q[0];
              // (RL5) Match event
              evt_q.match_tgl <= ~evt_q.match_tgl;
              state_q         <= LINK_ADDR_ACK;
            end else begin
              state_q <= LINK_IDLE;
            end
          end
        end
        LINK_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            if (xmt_q) begin
              tx_sh_q <= cfg_q.tx_byte;
              oe_q    <= ~cfg_q.tx_byte[7];
              state_q <= LINK_TX;
            end else begin
              oe_q    <= 1'b0;
              state_q <= LINK_RX;
            end
          end
        end
        LINK_RX: begin
          if (scl_rise) begin
            shift_q   <= {shift_q[6:0], sda_s};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == `BITS_PER_BYTE) begin
            rx_byte_q    <= shift_q;
            evt_q.rx_tgl <= ~evt_q.rx_tgl;
            oe_q         <= 1'b1;
            state_q      <= LINK_RX_ACK;
          end
        end
        LINK_RX_ACK: begin
          if (scl_fall) begin
            oe_q      <= 1'b0;
            bit_cnt_q <= 4'h0;
            state_q   <= LINK_RX;
          end
        end
        LINK_TX: begin
          if (scl_rise) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_q == `BITS_PER_BYTE) begin
              oe_q    <= 1'b0;
              state_q <= LINK_TX_ACK;
            end else begin
              tx_sh_q <= {tx_sh_q[6:0], 1'b0};
              oe_q    <= ~tx_sh_q[6];
            end
          end
        end
        LINK_TX_ACK: begin
          if (scl_rise && sda_s) begin
            // Master declined more data
            state_q <= LINK_IDLE;
          end else if (scl_fall) begin
            bit_cnt_q <= 4'h0;
            tx_sh_q   <= cfg_q.tx_byte;
            oe_q      <= ~cfg_q.tx_byte[7];
            state_q   <= LINK_TX;
          end
        end
        default: begin
          state_q <= LINK_IDLE;
          oe_q    <= 1'b0;
        end
      endcase
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = oe_q;

endmodule : slave_event_flags

/* File: rtl/slave_flags_defines.svh */
// Register map, field positions, reset values and counts of the slave event flag block
`ifndef SLAVE_FLAGS_DEFINES_SVH
`define SLAVE_FLAGS_DEFINES_SVH

// Register indices as printed; byte address is four times the index
`define SLAVE_EVENT_FLAGS_IDX  8'hdb
`define SLAVE_STATUS_IDX       8'hdc
`define OWN_ADDRESS_IDX        8'hdd
`define SLAVE_DATA_IDX         8'hde

`define SLAVE_EVENT_FLAGS_ADDR 12'h36c
`define SLAVE_STATUS_ADDR      12'h370
`define OWN_ADDRESS_ADDR       12'h374
`define SLAVE_DATA_ADDR        12'h378

// Field positions in slave_event_flags
`define FIRST_BYTE_BIT         7
`define DUAL_ADDRESS_BIT       7
`define ADDRESS_MATCH_BIT      6
`define STOP_DETECTED_BIT      5

// Field position in the status register
`define TRANSMIT_DIRECTION_BIT 0

// Reset values
`define SLAVE_EVENT_FLAGS_RST  8'h00
`define OWN_ADDRESS_RST        7'h00
`define TX_DATA_RST            8'h00

// Bits in one byte on the wire
`define BITS_PER_BYTE          4'h8

`endif

/* File: rtl/slave_flags_pkg.sv */
// Types shared by the slave event flag block
package slave_flags_pkg;

  // Link side protocol states
  typedef enum logic [2:0] {
    LINK_IDLE     = 3'b000,
    LINK_ADDR     = 3'b001,
    LINK_ADDR_ACK = 3'b010,
    LINK_RX       = 3'b011,
    LINK_RX_ACK   = 3'b100,
    LINK_TX       = 3'b101,
    LINK_TX_ACK   = 3'b110
  } link_state_type;

  // Configuration handed from the bus side to the link side
  typedef struct packed {
    logic       dual_address_enable;
    logic [6:0] own_address;
    logic [7:0] tx_byte;
  } link_cfg_type;

  // Event toggles handed from the link side to the bus side
  typedef struct packed {
    logic match_tgl;
    logic stop_tgl;
    logic rx_tgl;
  } link_evt_type;

endpackage : slave_flags_pkg

/* File: verif/i2c_master_model.sv */
// Behavioural two-wire bus master that drives SCL and pulls or releases SDA
`timescale 1ns/1ps

module i2c_master_model (
  output logic      scl,
  output logic      sda_rel,
  input  wire logic sda
);
  localparam int HALF = 320;
  localparam int QTR  = 160;

  // Idle bus: both lines at the pull-up level
  initial begin
    scl     = 1'b1;
    sda_rel = 1'b1;
  end

  // Data moves a quarter period after SCL falls, clear of the slave's sync lag
  task automatic put_bit(input logic b);
    #QTR sda_rel = b;
    #QTR scl = 1'b1;
    #HALF scl = 1'b0;
  endtask : put_bit

  // Released line is sampled mid high phase
  task automatic get_bit(output logic b);
    #QTR sda_rel = 1'b1;
    #QTR scl = 1'b1;
    #QTR b = sda;
    #QTR scl = 1'b0;
  endtask : get_bit

  task automatic start;
    sda_rel = 1'b1;
    #HALF sda_rel = 1'b0;
    #HALF scl = 1'b0;
  endtask : start

  task automatic stop;
    #QTR sda_rel = 1'b0;
    #QTR scl = 1'b1;
    #HALF sda_rel = 1'b1;
    #HALF;
  endtask : stop

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(b);
    ack = !b;
  endtask : send_byte

  task automatic recv_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!ack);
  endtask : recv_byte
endmodule : i2c_master_model

/* File: verif/slave_event_flags_chk.sv */
// Concurrent checks on the ports of the slave event flag block
`timescale 1ns/1ps
`include "slave_flags_defines.svh"

module slave_event_flags_chk
  import slave_flags_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        slave_irq,
  input wire logic        link_clk,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe
);
  logic       acc;
  logic       rd_flags;
  logic       rd_data;
  logic       rd_stat;
  logic       wr_flags;
  logic       match_seen_q;
  logic       stop_seen_q;
  logic       scl_prev_q;
  logic [4:0] quiet_q;

  // Completed transfer decode
  assign acc      = psel && penable && pready;
  assign rd_flags = acc && !pwrite && paddr == `SLAVE_EVENT_FLAGS_ADDR;
  assign wr_flags = acc && pwrite && paddr == `SLAVE_EVENT_FLAGS_ADDR;
  assign rd_data  = acc && !pwrite && paddr == `SLAVE_DATA_ADDR;
  assign rd_stat  = acc && !pwrite && paddr == `SLAVE_STATUS_ADDR;

  // Flags software saw set; only a zero write may drop them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_seen_q <= 1'b0;
      stop_seen_q  <= 1'b0;
    end else if (wr_flags) begin
      match_seen_q <= match_seen_q & pwdata[6];
      stop_seen_q  <= stop_seen_q & pwdata[5];
    end else if (rd_flags) begin
      match_seen_q <= match_seen_q | prdata[6];
      stop_seen_q  <= stop_seen_q | prdata[5];
    end
  end

  // Cycles since SCL moved; link events land a few cycles after the pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_prev_q <= 1'b1;
      quiet_q    <= 5'h00;
    end else begin
      scl_prev_q <= scl_in;
      if (scl_in != scl_prev_q) begin
        quiet_q <= 5'h00;
      end else if (quiet_q != 5'h1f) begin
        quiet_q <= quiet_q + 5'h01;
      end
    end
  end

  a_irq_mirrors_flags: assert property (@(posedge pclk) disable iff (!presetn)
    rd_flags |-> slave_irq == (prdata[6] | prdata[5]))
    else $error("interrupt disagrees with flags read");
  a_match_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    rd_flags && match_seen_q |-> prdata[6])
    else $error("match flag dropped without software");
  a_stop_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    rd_flags && stop_seen_q |-> prdata[5])
    else $error("stop flag dropped without software");
  a_first_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_data && quiet_q == 5'h1f ##[1:4] rd_flags) |-> !prdata[7])
    else $error("first byte mark kept after data read");
  a_status_bits: assert property (@(posedge pclk) disable iff (!presetn)
    rd_stat |-> prdata[31:1] == 31'h0)
    else $error("status upper bits not zero");
  a_ack_release: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(sda_oe) |-> ##[1:400] !sda_oe)
    else $error("slave holds data line too long");
endmodule : slave_event_flags_chk

bind slave_event_flags slave_event_flags_chk i_slave_event_flags_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .slave_irq(slave_irq), .link_clk(link_clk),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe)
);

/* File: verif/tb.sv */
// Self-checking bench for the slave event flag block
`timescale 1ns/1ps
`include "slave_flags_defines.svh"

module tb;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slave_irq;
  logic        link_clk;
  logic        scl;
  logic        sda_rel;
  logic        sda_out;
  logic        sda_oe;
  wire         sda;
  logic        ack;
  logic [7:0]  rx;
  logic [31:0] rd;
  logic        last_err;
  int          err_total;
  int          tests_run;

  // Clocks; link clock offset so the domains never line up
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #16 link_clk = ~link_clk;
  end

  // Open-drain data line with pull-up
  assign sda = sda_rel & ~(sda_oe & ~sda_out);

  slave_event_flags i_slave_event_flags (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slave_irq(slave_irq), .link_clk(link_clk),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe)
  );
  i2c_master_model i_i2c_master_model (.scl(scl), .sda_rel(sda_rel), .sda(sda));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One transfer; held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, {24'h0, exp});
  endtask : rd_chk

  // Lets link events cross into the bus domain
  task automatic settle;
    repeat (40) @(posedge pclk);
  endtask : settle

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the expected run of about 6.7k cycles
  initial begin
    #400000;
    err_total++;
    test_done;
  end

  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    settle;
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h00);
    apb(1'b0, 12'h000, 32'hffff_ffff);
    check({31'h0, last_err}, 32'h1);
    $display("test reset done");
    wr(`OWN_ADDRESS_ADDR, 8'h50);
    rd_chk(`OWN_ADDRESS_ADDR, 8'h50);
    wr(`SLAVE_EVENT_FLAGS_ADDR, 8'h00);
    settle;
    i_i2c_master_model.start;
    i_i2c_master_model.send_byte({7'h50, 1'b0}, ack);
    check({31'h0, ack}, 32'h1);
    settle;
    rd_chk(`SLAVE_STATUS_ADDR, 8'h00);
    i_i2c_master_model.send_byte(8'ha5, ack);
    settle;
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'hc0);
    check({31'h0, slave_irq}, 32'h1);
    rd_chk(`SLAVE_DATA_ADDR, 8'ha5);
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h40);
    i_i2c_master_model.send_byte(8'h3c, ack);
    settle;
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h40);
    i_i2c_master_model.stop;
    settle;
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h60);
    wr(`SLAVE_EVENT_FLAGS_ADDR, 8'h60);
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h60);
    wr(`SLAVE_EVENT_FLAGS_ADDR, 8'h00);
    settle;
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h00);
    check({31'h0, slave_irq}, 32'h0);
    $display("test receive done");
    i_i2c_master_model.start;
    i_i2c_master_model.send_byte({7'h51, 1'b0}, ack);
    check({31'h0, ack}, 32'h0);
    i_i2c_master_model.stop;
    settle;
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h20);
    wr(`SLAVE_EVENT_FLAGS_ADDR, 8'h80);
    settle;
    // Both neighbours match once the address LSB is ignored
    for (int k = 0; k < 2; k++) begin
      i_i2c_master_model.start;
      i_i2c_master_model.send_byte({6'h28, k[0], 1'b0}, ack);
      check({31'h0, ack}, 32'h1);
      i_i2c_master_model.stop;
      settle;
      rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h60);
      wr(`SLAVE_EVENT_FLAGS_ADDR, 8'h80);
    end
    $display("test dual address done");
    wr(`SLAVE_DATA_ADDR, 8'h96);
    settle;
    i_i2c_master_model.start;
    i_i2c_master_model.send_byte({7'h50, 1'b1}, ack);
    check({31'h0, ack}, 32'h1);
    settle;
    rd_chk(`SLAVE_STATUS_ADDR, 8'h01);
    // Master acknowledges the first byte, so the same byte is sent again
    i_i2c_master_model.recv_byte(rx, 1'b1);
    check({24'h0, rx}, 32'h96);
    i_i2c_master_model.recv_byte(rx, 1'b0);
    check({24'h0, rx}, 32'h96);
    i_i2c_master_model.stop;
    settle;
    rd_chk(`SLAVE_STATUS_ADDR, 8'h00);
    rd_chk(`SLAVE_EVENT_FLAGS_ADDR, 8'h60);
    $display("test transmit done");
    test_done;
  end
endmodule : tb
